// ==== dpr_port.sv ====
// one port of a synchronous dual-port ram, 16k words of 18 bits
// assumes the host drives all synchronous inputs on i_clk; output
// enable and latency select are asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module dpr_port (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [13:0] i_addr,
	input wire logic [17:0] i_data,
	input wire logic i_write_n,
	input wire logic i_address_strobe_n,
	input wire logic i_count_advance_n,
	input wire logic i_count_clear_n,
	input wire logic i_chip_select_low_n,
	input wire logic i_chip_select_high,
	input wire logic i_upper_lane_sel_n,
	input wire logic i_lower_lane_sel_n,
	input wire logic i_output_enable_n,
	input wire logic i_output_latency_sel,
	output logic [17:0] o_data,
	output logic [1:0] o_data_oe_n,
	output logic o_powered_down
);
	logic [17:0] mem_r [0:dpr_pkg::DEPTH-1];
	logic [13:0] cnt_r;
	logic [13:0] addr_nxt;
	logic [17:0] rd_r;
	logic [17:0] dout_r;
	logic [1:0] lane_sel;
	logic [1:0] drive_ft_r;
	logic [1:0] drive_pl_r;
	logic [1:0] drive;
	logic sel;
	logic rd_en;
	logic wr_en;
	logic pipe_mode;
	logic oe_n_sync;
	logic [1:0] react_r;
	logic [1:0] lane_r;
	dpr_pkg::dpr_pwr_e pwr_r;

	// signal groups, in the order they are used below:
	// - pin filters for the two asynchronous controls
	// - decode of the chip enables, lane selects and direction
	// - address path: clear, load, advance or hold, then counter
	// - storage: lane-masked write and read register
	// - output stage: optional pipeline flop
	// - power state with reactivation count for pipelined mode
	// - drive enables of the output stage

	// asynchronous pins pass the three-flop filter
	dpr_sync3 u_sync_pipe (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_async(i_output_latency_sel),
		.o_level(pipe_mode)
	);
	dpr_sync3 u_sync_oe (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_async(i_output_enable_n),
		.o_level(oe_n_sync)
	);

	// decoded controls of this edge
	assign sel = !i_chip_select_low_n && i_chip_select_high;
	assign lane_sel = {!i_upper_lane_sel_n, !i_lower_lane_sel_n};
	assign wr_en = sel && !i_write_n && (lane_sel != 2'h0);
	assign rd_en = sel && i_write_n;

	// internal address: clear, load, advance or hold
	always_comb begin
		if (!i_count_clear_n) begin
			addr_nxt = dpr_pkg::ADDR_RST;
		end else if (!i_address_strobe_n) begin
			addr_nxt = i_addr;
		end else if (!i_count_advance_n) begin
			addr_nxt = cnt_r + 14'h0001;
		end else begin
			addr_nxt = cnt_r;
		end
	end

	// counter follows the accessed address
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cnt_r <= dpr_pkg::ADDR_RST;
		end else begin
			cnt_r <= addr_nxt;
		end
	end

	// lane-masked write on the captured edge
	// one process owns the array, so the two lanes never become two
	// drivers of the same variable; the write lands on the same address
	// that the counter takes this edge, which covers advance and clear
	always_ff @(posedge i_clk) begin
		for (int k = 0; k < 2; k++) begin
			if (wr_en && lane_sel[k]) begin
				mem_r[addr_nxt][k*dpr_pkg::LANE_W +: dpr_pkg::LANE_W] <=
					i_data[k*dpr_pkg::LANE_W +: dpr_pkg::LANE_W];
			end
		end
	end

	// read register; held when not reading (deselected or writing)
	always_ff @(posedge i_clk) begin
		if (rd_en) begin
			rd_r <= mem_r[addr_nxt];
		end
	end

	// lane selects are single buffered in both modes
	// a lane that is deselected floats after the very next edge even
	// when the chip enables travel through the extra pipelined stage
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			lane_r <= 2'h0;
		end else begin
			lane_r <= lane_sel;
		end
	end

	// pipeline output stage
	// flow-through mode bypasses this flop at the output mux
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			dout_r <= dpr_pkg::DOUT_RST;
		end else begin
			dout_r <= rd_r;
		end
	end

	// power state: down on deselect, wake needs selected cycles
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			pwr_r <= dpr_pkg::DPR_ACTIVE;
			react_r <= 2'h0;
		end else begin
			case (pwr_r)
				// running: one deselected cycle is enough to power down
				dpr_pkg::DPR_ACTIVE: begin
					if (!sel) begin
						pwr_r <= dpr_pkg::DPR_DOWN;
					end
				end
				// powered down: first selected cycle starts the count
				dpr_pkg::DPR_DOWN: begin
					if (sel) begin
						pwr_r <= dpr_pkg::DPR_WAKE;
						react_r <= 2'h1;
					end
				end
				// waking: flow-through is done at once, pipelined counts
				// to the reactivation limit; a deselect restarts it
				dpr_pkg::DPR_WAKE: begin
					if (!sel) begin
						pwr_r <= dpr_pkg::DPR_DOWN;
						react_r <= 2'h0;
					end else if (!pipe_mode || react_r + 2'h1 >= dpr_pkg::REACT_MAX) begin
						pwr_r <= dpr_pkg::DPR_ACTIVE;
						react_r <= 2'h0;
					end else begin
						react_r <= react_r + 2'h1;
					end
				end
				default: begin
					pwr_r <= dpr_pkg::DPR_ACTIVE;
				end
			endcase
		end
	end

	// drive decision from previous-cycle controls
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			drive_ft_r <= 2'h0;
		end else begin
			drive_ft_r <= (rd_en && pwr_r != dpr_pkg::DPR_DOWN) ? lane_sel : 2'h0;
		end
	end

	// pipelined mode: chip enables double buffered
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			drive_pl_r <= 2'h0;
		end else begin
			drive_pl_r <= (pwr_r == dpr_pkg::DPR_ACTIVE) ? drive_ft_r : 2'h0;
		end
	end

	// pipelined drive: enables double buffered, lanes single buffered
	assign drive = pipe_mode ? (drive_pl_r & lane_r) : drive_ft_r;
	assign o_data = pipe_mode ? dout_r : rd_r;
	// output enable gates drivers once it has passed the three-flop filter
	assign o_data_oe_n = ~(drive & {2{!oe_n_sync}});
	assign o_powered_down = (pwr_r == dpr_pkg::DPR_DOWN);
endmodule
`default_nettype wire

// ==== dpr_pkg.sv ====
// package for one port of a synchronous dual-port ram, 16k x 18
// assumes a single 250 MHz clock domain on the port side
package dpr_pkg;
	localparam int ADDR_W = 14;
	localparam int DATA_W = 18;
	localparam int LANE_W = 9;
	localparam int DEPTH = 16384;
	localparam logic [13:0] ADDR_RST = 14'h0000;
	localparam logic [17:0] DOUT_RST = 18'h00000;
	localparam int LOWER_LSB = 0;
	localparam int UPPER_LSB = 9;
	// cycles of select before a pipelined port drives again
	localparam int REACT_CYC = 2;
	localparam logic [1:0] REACT_MAX = 2'h2;
	typedef enum logic [2:0] {
		DPR_ACTIVE = 3'b001,
		DPR_DOWN = 3'b010,
		DPR_WAKE = 3'b100
	} dpr_pwr_e;
endpackage

// ==== dpr_sync3.sv ====
// three-flop synchroniser with agreement filter for asynchronous levels
// assumes the input may change at any time relative to i_clk
`timescale 1ns/1ps
`default_nettype none
module dpr_sync3 (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_async,
	output logic o_level
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	// shift chain; first flop only feeds the second
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= i_async;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// level changes once second and third agree
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_level <= 1'b0;
		end else if (s2_r == s3_r) begin
			o_level <= s3_r;
		end
	end
endmodule
`default_nettype wire

// ==== dpr_port_checker.sv ====
// pin assertions for one ram port
// bound to dpr_port, one clock domain
`timescale 1ns/1ps
`default_nettype none
module dpr_port_checker (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_write_n,
	input wire logic i_address_strobe_n,
	input wire logic i_count_advance_n,
	input wire logic i_count_clear_n,
	input wire logic i_chip_select_low_n,
	input wire logic i_chip_select_high,
	input wire logic i_upper_lane_sel_n,
	input wire logic i_lower_lane_sel_n,
	input wire logic i_output_enable_n,
	input wire logic [17:0] o_data,
	input wire logic [1:0] o_data_oe_n,
	input wire logic o_powered_down
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	// selected, idle and full-read conditions
	wire sel = i_chip_select_high && !i_chip_select_low_n;
	wire hold = sel && i_write_n && i_address_strobe_n && i_count_advance_n && i_count_clear_n;
	wire rdok = sel && i_write_n && !i_output_enable_n && !i_upper_lane_sel_n && !i_lower_lane_sel_n;
	desel_down_a: assert property (!sel |=> o_powered_down) else $error("no power down");
	desel_float_a: assert property (!sel[*2] |=> o_data_oe_n == 2'h3) else $error("drives");
	wake_up_a: assert property (sel[*3] |=> !o_powered_down) else $error("no wake");
	upper_float_a: assert property (i_upper_lane_sel_n[*2] |=> o_data_oe_n[1]) else $error("up");
	lower_float_a: assert property (i_lower_lane_sel_n |=> o_data_oe_n[0]) else $error("low");
	oe_float_a: assert property (i_output_enable_n[*6] |-> o_data_oe_n == 2'h3) else $error("oe");
	read_drive_a: assert property (rdok[*6] |=> o_data_oe_n == 2'h0) else $error("idle");
	hold_data_a: assert property ((hold && !o_powered_down)[*3] |=>
		o_data === $past(o_data)) else $error("data moved");
endmodule
bind dpr_port dpr_port_checker i_dpr_port_checker (.*);
`default_nettype wire

// ==== dpr_host.sv ====
// host model of the data pins; a floating lane
// shows the inverse of its last level each cycle
`timescale 1ns/1ps
`default_nettype none
module dpr_host (
	input wire logic i_clk,
	input wire logic [17:0] i_data,
	input wire logic [1:0] i_oe_n,
	output logic [17:0] o_bus
);
	logic [17:0] last_r;
	// lanes carry data only while driven
	assign o_bus = {i_oe_n[1] ? ~last_r[17:9] : i_data[17:9], i_oe_n[0] ? ~last_r[8:0] : i_data[8:0]};
	// remember bus levels
	always_ff @(posedge i_clk) last_r <= o_bus;
endmodule
`default_nettype wire

// ==== test_dpr_port.sv ====
// testbench for one ram port and host model
// drives pins at the rising edge, no far port
`timescale 1ns/1ps
`default_nettype none
module test_dpr_port;
	localparam logic [13:0] AD = 14'h1A2C;
	localparam logic [17:0] D1 = 18'h2A5A5, D2 = 18'h15A5A, D3 = 18'h3C3C3, D4 = 18'h0F0F0;
	logic clk = 0, rst = 1, w_n = 1, ads_n = 1, cnt_n = 1, clr_n = 1, cs = 1, ub_n = 0, lb_n = 0;
	logic oe_n = 0, lat = 0, pd, cs0_n = 0;
	logic [13:0] a = 0;
	logic [17:0] d = 0, q, bus;
	logic [1:0] oen;
	int mismatches = 0, checks_done = 0;
	dpr_port i_dpr_port (.i_clk(clk), .i_sys_rst(rst), .i_addr(a), .i_data(d), .i_write_n(w_n),
		.i_address_strobe_n(ads_n), .i_count_advance_n(cnt_n), .i_count_clear_n(clr_n),
		.i_chip_select_low_n(cs0_n), .i_chip_select_high(cs), .i_upper_lane_sel_n(ub_n),
		.i_lower_lane_sel_n(lb_n), .i_output_enable_n(oe_n), .i_output_latency_sel(lat),
		.o_data(q), .o_data_oe_n(oen), .o_powered_down(pd));
	dpr_host i_dpr_host (.i_clk(clk), .i_data(q), .i_oe_n(oen), .o_bus(bus));
	// clock
	initial forever #2 clk = ~clk;
	task chk(input logic [17:0] e, g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %0t exp %h got %h", $time, e, g);
		end
	endtask
	task op(input logic [3:0] c, input logic [13:0] ad, input logic [17:0] dt);
		@(posedge clk);
		{w_n, ads_n, cnt_n, clr_n} <= c;
		a <= ad;
		d <= dt;
	endtask
	task rd(input logic [13:0] ad, input logic [17:0] e);
		op(4'hB, ad, 0);
		lb_n <= 1'b0;
		op(4'hF, ad, 0);
		if (lat) @(posedge clk);
		#1 chk(e, bus);
		repeat (4) @(posedge clk);
		#1 chk(e, bus);
	endtask
	task t_write;
		op(4'h3, AD, D1);
		op(4'h5, AD, D2);
		op(4'h6, AD, D3);
		op(4'h3, AD, D4);
		lb_n <= 1'b1;
	endtask
	task t_read;
		rd(AD, {D4[17:9], D1[8:0]});
		rd(AD + 14'h1, D2);
		rd(14'h0, D3);
	endtask
	task t_down;
		@(posedge clk) cs <= 1'b0;
		repeat (3) @(posedge clk);
		#1 chk(18'h1, {17'h0, pd});
		@(posedge clk) cs <= 1'b1;
		rd(14'h0, D3);
		@(posedge clk) cs0_n <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk(18'h1, {17'h0, pd});
		@(posedge clk) cs0_n <= 1'b0;
		rd(AD + 14'h1, D2);
	endtask
	task t_oe;
		@(posedge clk) {oe_n, ub_n} <= 2'h3;
		repeat (6) @(posedge clk);
		#1 chk(18'h3, {16'h0, oen});
		@(posedge clk) {oe_n, ub_n} <= 2'h0;
		repeat (6) @(posedge clk);
	endtask
	task results;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// watchdog
	initial begin
		#8000;
		mismatches++;
		results();
	end
	// main sequence
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		t_write();
		t_read();
		t_oe();
		@(posedge clk) lat <= 1'b1;
		repeat (6) @(posedge clk);
		t_read();
		t_down();
		results();
	end
endmodule
`default_nettype wire
